// ==== bmd_board.sv ====
// board strap model driving the boot and config pins
`timescale 1ns/1ps
`default_nettype none
module bmd_board (
	input wire logic [7:0] strap_in,
	input wire logic [2:0] amem_in,
	output logic [3:0] boot_type_out,
	output logic speed_up_out,
	output logic [2:0] mul_sel_out,
	output logic [2:0] amem_out
);
	assign {boot_type_out, speed_up_out, mul_sel_out} = strap_in;
	assign amem_out = amem_in;
endmodule : bmd_board
`default_nettype wire

// ==== bmd_cfg.svh ====
// offsets, encodings, reset values and counts for the boot defaults block
`ifndef BMD_CFG_SVH
`define BMD_CFG_SVH

// boot type codes
`define BMD_BT_NONE 4'h0
`define BMD_BT_HOST 4'h2
`define BMD_BT_AROM 4'h4
`define BMD_BT_I2C 4'h5
`define BMD_BT_SPI16 4'h6
`define BMD_BT_NAND 4'h7
`define BMD_BT_UART 4'h8
`define BMD_BT_AROM_NA 4'h9
`define BMD_BT_LINK 4'ha
`define BMD_BT_UART_FC 4'he
`define BMD_BT_SPI24 4'hf

// start addresses
`define BMD_ADDR_ROM 32'h0010_0000
`define BMD_ADDR_AROM 32'h0420_0000

// module state codes
`define BMD_ST_SRD 2'h0
`define BMD_ST_EN 2'h3

// domain indices
`define BMD_NDOM 40
`define BMD_DOM_AMEM 14
`define BMD_DOM_CPU 39

// async memory config value that disables its domain
`define BMD_AMEM_OFF 3'h0

// multipliers
`define BMD_MUL_BYPASS 5'h01
`define BMD_MUL_LINK 5'h14

// core clock dividers
`define BMD_DIV_1 2'h1
`define BMD_DIV_2 2'h2

// value the wait counter counts up to after reset release before the pin capture state is entered
`define BMD_CAPTURE_DLY 4'h3

`endif

// ==== bmd_checker.sv ====
// concurrent checks on the boot defaults block ports
`timescale 1ns/1ps
`default_nettype none
`include "bmd_cfg.svh"
module bmd_checker
	import bmd_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [3:0] boot_type_in,
	input wire logic speed_up_in,
	input wire logic [2:0] pll_multiplier_select_in,
	input wire logic [2:0] async_mem_config_pins_in,
	input wire logic [7:0] boot_config_capture_out,
	input wire logic [31:0] cpu_start_address_out,
	input wire logic [4:0] pll_mul_out,
	input wire logic pll_bypass_out,
	input wire logic [1:0] core_clock_divider_out,
	input wire logic [2*`BMD_NDOM-1:0] module_state_field_out,
	input wire logic cpu_release_out,
	input wire logic boot_start_out
);
	logic [3:0] bt;
	logic su;
	logic [79:0] dom;
	assign bt = boot_config_capture_out[7:4];
	assign su = boot_config_capture_out[3];
	assign dom = module_state_field_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	AST_ADDR: assert property (cpu_release_out |-> cpu_start_address_out ==
		((bt == 4'h4 && !su) ? 32'h0420_0000 : 32'h0010_0000))
		else $error("start address wrong");
	AST_BYPASS: assert property (cpu_release_out |->
		pll_bypass_out == (!su || bt == 4'h0)) else $error("bypass wrong");
	AST_DIV: assert property (cpu_release_out |-> core_clock_divider_out ==
		(pll_bypass_out ? 2'h1 : 2'h2)) else $error("divider wrong");
	AST_MUL: assert property (cpu_release_out && pll_bypass_out |->
		pll_mul_out == 5'h01) else $error("multiplier used in bypass");
	AST_CPU_DOM: assert property (cpu_release_out |-> dom[79:78] == 2'h3)
		else $error("cpu domain not enabled");
	AST_PERIPH_DOM: assert property (cpu_release_out |->
		dom[77:30] == 48'h0 && dom[27:0] == 28'h0) else $error("domain state");
	AST_AMEM: assert property (boot_start_out |=> dom[29:28] ==
		((async_mem_config_pins_in == 3'h0) ? 2'h0 : 2'h3))
		else $error("async memory domain state wrong");
	AST_PULSE: assert property (boot_start_out |-> !cpu_release_out ##1
		(!boot_start_out && cpu_release_out)) else $error("boot start sequence");
	AST_HOLD: assert property (cpu_release_out |=> cpu_release_out &&
		$stable(boot_config_capture_out)) else $error("capture not held");
	AST_CAP: assert property (boot_start_out |=> boot_config_capture_out ==
		{boot_type_in, speed_up_in, pll_multiplier_select_in})
		else $error("capture byte wrong");
endmodule : bmd_checker
bind bmd_top bmd_checker u_chk (.clk_in, .nrst_in, .boot_type_in, .speed_up_in,
	.pll_multiplier_select_in, .async_mem_config_pins_in,
	.boot_config_capture_out, .cpu_start_address_out, .pll_mul_out,
	.pll_bypass_out, .core_clock_divider_out, .module_state_field_out,
	.cpu_release_out, .boot_start_out);
`default_nettype wire

// ==== bmd_decode.sv ====
// decoder from captured boot pins to boot settings and domain defaults
`timescale 1ns/1ps
`default_nettype none
`include "bmd_cfg.svh"
module bmd_decode
	import bmd_pkg::*;
(
	bmd_if.dst cfg,
	output logic [31:0] start_addr,
	output logic [4:0] pll_mul,
	output logic [1:0] clk_div,
	output logic pll_bypass,
	output logic is_slave,
	output logic bt_invalid,
	output logic cache_off,
	output logic [2*`BMD_NDOM-1:0] dom_state
);
	logic [3:0] bt;
	logic fb;
	always_comb begin
		bt = cfg.cap.boot_type;
		fb = cfg.cap.speed_up;
		is_slave = (bt == `BMD_BT_HOST) || (bt == `BMD_BT_LINK);
		case (bt)
			4'h1, 4'h3, 4'hb, 4'hc, 4'hd: bt_invalid = 1'b1;
			4'h9: bt_invalid = !fb;
			default: bt_invalid = 1'b0;
		endcase
		pll_bypass = !fb || (bt == `BMD_BT_NONE);
		pll_mul = `BMD_MUL_BYPASS;
		if (!pll_bypass) begin
			if ((bt == `BMD_BT_LINK) || (bt == `BMD_BT_SPI24)) begin
				pll_mul = `BMD_MUL_LINK;
			end else begin
				case (cfg.cap.pll_multiplier_select)
					3'h0: pll_mul = 5'h14;
					3'h1: pll_mul = 5'h0f;
					3'h2: pll_mul = 5'h10;
					3'h3: pll_mul = 5'h12;
					3'h4: pll_mul = 5'h16;
					3'h5: pll_mul = 5'h19;
					3'h6: pll_mul = 5'h1b;
					default: pll_mul = 5'h1e;
				endcase
			end
		end
		clk_div = pll_bypass ? `BMD_DIV_1 : `BMD_DIV_2;
		if (!fb && (bt == `BMD_BT_AROM)) begin
			start_addr = `BMD_ADDR_AROM;
		end else begin
			start_addr = `BMD_ADDR_ROM;
		end
		cache_off = (start_addr == `BMD_ADDR_ROM);
	end

	// per domain default state
	genvar i;
	generate
		for (i = 0; i < `BMD_NDOM; i = i + 1) begin : g_dom
			if (i == `BMD_DOM_CPU) begin : g_cpu
				assign dom_state[2*i+:2] = `BMD_ST_EN;
			end else if (i == `BMD_DOM_AMEM) begin : g_amem
				assign dom_state[2*i+:2] = (cfg.amem == `BMD_AMEM_OFF) ?
					`BMD_ST_SRD : `BMD_ST_EN;
			end else begin : g_per
				assign dom_state[2*i+:2] = `BMD_ST_SRD;
			end
		end
	endgenerate
endmodule : bmd_decode
`default_nettype wire

// ==== bmd_if.sv ====
// captured configuration carried from the capture stage to the decoder
`timescale 1ns/1ps
`default_nettype none
interface bmd_if;
	import bmd_pkg::*;
	bmd_capture_t cap;
	logic [2:0] amem;
	logic valid;
	modport src (output cap, output amem, output valid);
	modport dst (input cap, input amem, input valid);
endinterface : bmd_if
`default_nettype wire

// ==== bmd_pkg.sv ====
// types for the boot defaults block
package bmd_pkg;

	typedef logic [1:0] bmd_state_t;

	typedef struct packed {
		logic [3:0] boot_type;
		logic speed_up;
		logic [2:0] pll_multiplier_select;
	} bmd_capture_t;

	typedef enum logic [2:0] {
		BMD_WAIT = 3'h1,
		BMD_LATCH = 3'h2,
		BMD_RUN = 3'h4
	} bmd_fsm_t;

endpackage : bmd_pkg

// ==== bmd_top.sv ====
// boot pin capture and reset-time module defaults
`timescale 1ns/1ps
`default_nettype none
`include "bmd_cfg.svh"
module bmd_top
	import bmd_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [3:0] boot_type_in,
	input wire logic speed_up_in,
	input wire logic [2:0] pll_multiplier_select_in,
	input wire logic [2:0] async_mem_config_pins_in,
	output logic [7:0] boot_config_capture_out,
	output logic [31:0] cpu_start_address_out,
	output logic [4:0] pll_mul_out,
	output logic pll_bypass_out,
	output logic [1:0] core_clock_divider_out,
	output logic is_slave_out,
	output logic boot_type_invalid_out,
	output logic cache_disable_out,
	output logic [2*`BMD_NDOM-1:0] module_state_field_out,
	output logic cpu_release_out,
	output logic boot_start_out
);
	//--------------------------------------------------
	// reset release
	//--------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	//--------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------
	logic [10:0] pin_s1_ff;
	logic [10:0] pin_s2_ff;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= 11'h000;
			pin_s2_ff <= 11'h000;
		end else begin
			pin_s1_ff <= {async_mem_config_pins_in, boot_type_in,
				speed_up_in, pll_multiplier_select_in};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	//--------------------------------------------------
	// capture sequencer
	//--------------------------------------------------
	bmd_fsm_t st_ff;
	bmd_fsm_t nxt_st;
	logic [3:0] dly_ff;
	logic [3:0] nxt_dly;
	bmd_capture_t cap_ff;
	bmd_capture_t nxt_cap;
	logic [2:0] amem_ff;
	logic [2:0] nxt_amem;
	logic start_ff;
	logic nxt_start;
	always_comb begin
		nxt_st = st_ff;
		nxt_dly = dly_ff;
		nxt_cap = cap_ff;
		nxt_amem = amem_ff;
		nxt_start = 1'b0;
		case (st_ff)
			BMD_WAIT: begin
				// wait for synchronisers to fill
				if (dly_ff == `BMD_CAPTURE_DLY) begin
					nxt_st = BMD_LATCH;
				end else begin
					nxt_dly = dly_ff + 4'h1;
				end
			end
			BMD_LATCH: begin
				nxt_cap.boot_type = pin_s2_ff[7:4];
				nxt_cap.speed_up = pin_s2_ff[3];
				nxt_cap.pll_multiplier_select = pin_s2_ff[2:0];
				nxt_amem = pin_s2_ff[10:8];
				nxt_start = 1'b1;
				nxt_st = BMD_RUN;
			end
			BMD_RUN: begin
				nxt_st = BMD_RUN;
			end
			default: begin
				nxt_st = BMD_WAIT;
			end
		endcase
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= BMD_WAIT;
			dly_ff <= 4'h0;
			cap_ff <= '0;
			amem_ff <= 3'h0;
			start_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			dly_ff <= nxt_dly;
			cap_ff <= nxt_cap;
			amem_ff <= nxt_amem;
			start_ff <= nxt_start;
		end
	end

	//--------------------------------------------------
	// decode
	//--------------------------------------------------
	bmd_if cfg_if ();
	assign cfg_if.cap = cap_ff;
	assign cfg_if.amem = amem_ff;
	assign cfg_if.valid = (st_ff == BMD_RUN);

	logic [31:0] d_addr;
	logic [4:0] d_mul;
	logic [1:0] d_div;
	logic d_byp;
	logic d_slave;
	logic d_inv;
	logic d_cache;
	logic [2*`BMD_NDOM-1:0] d_dom;
	bmd_decode u_dec (
		.cfg(cfg_if.dst),
		.start_addr(d_addr),
		.pll_mul(d_mul),
		.clk_div(d_div),
		.pll_bypass(d_byp),
		.is_slave(d_slave),
		.bt_invalid(d_inv),
		.cache_off(d_cache),
		.dom_state(d_dom)
	);

	//--------------------------------------------------
	// output registers
	//--------------------------------------------------
	logic [7:0] o_cap_ff;
	logic [31:0] o_addr_ff;
	logic [4:0] o_mul_ff;
	logic o_byp_ff;
	logic [1:0] o_div_ff;
	logic o_slave_ff;
	logic o_inv_ff;
	logic o_cache_ff;
	logic [2*`BMD_NDOM-1:0] o_dom_ff;
	logic o_rel_ff;
	logic nxt_rel;
	always_comb begin
		nxt_rel = o_rel_ff | start_ff;
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			o_cap_ff <= 8'h00;
			o_addr_ff <= `BMD_ADDR_ROM;
			o_mul_ff <= `BMD_MUL_BYPASS;
			o_byp_ff <= 1'b1;
			o_div_ff <= `BMD_DIV_1;
			o_slave_ff <= 1'b0;
			o_inv_ff <= 1'b0;
			o_cache_ff <= 1'b1;
			o_dom_ff <= '0;
			o_rel_ff <= 1'b0;
		end else begin
			o_cap_ff <= cap_ff;
			o_addr_ff <= d_addr;
			o_mul_ff <= d_mul;
			o_byp_ff <= d_byp;
			o_div_ff <= d_div;
			o_slave_ff <= d_slave;
			o_inv_ff <= d_inv;
			o_cache_ff <= d_cache;
			o_dom_ff <= d_dom;
			o_rel_ff <= nxt_rel;
		end
	end

	assign boot_config_capture_out = o_cap_ff;
	assign cpu_start_address_out = o_addr_ff;
	assign pll_mul_out = o_mul_ff;
	assign pll_bypass_out = o_byp_ff;
	assign core_clock_divider_out = o_div_ff;
	assign is_slave_out = o_slave_ff;
	assign boot_type_invalid_out = o_inv_ff;
	assign cache_disable_out = o_cache_ff;
	assign module_state_field_out = o_dom_ff;
	assign cpu_release_out = o_rel_ff;
	assign boot_start_out = start_ff;
endmodule : bmd_top
`default_nettype wire

// ==== boot_mode_and_module_defaults_bench.sv ====
// self-checking bench for the boot defaults block
`timescale 1ns/1ps
`default_nettype none
module boot_mode_and_module_defaults_bench;
	localparam logic [39:0] muls_tbl = {5'h1e, 5'h1b, 5'h19, 5'h16,
		5'h12, 5'h10, 5'h0f, 5'h14};
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] strap = 8'h00;
	logic [2:0] amem = 3'h0;
	logic [31:0] rs = 32'hbeac;
	logic [7:0] c;
	logic [2:0] a3;
	logic [131:0] expq[$];
	logic [131:0] want;
	int n_mismatch = 0;
	int n_checks = 0;
	wire logic [3:0] bt;
	wire logic su;
	wire logic [2:0] ms, am;
	logic [7:0] cap;
	logic [31:0] addr;
	logic [4:0] mul;
	logic byp, slv, inv, cch, rel, bst;
	logic [1:0] dv;
	logic [79:0] dom;
	always #10 clk_in = ~clk_in;
	bmd_board board (.strap_in(strap), .amem_in(amem), .boot_type_out(bt),
		.speed_up_out(su), .mul_sel_out(ms), .amem_out(am));
	bmd_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .boot_type_in(bt),
		.speed_up_in(su), .pll_multiplier_select_in(ms),
		.async_mem_config_pins_in(am), .boot_config_capture_out(cap),
		.cpu_start_address_out(addr), .pll_mul_out(mul), .pll_bypass_out(byp),
		.core_clock_divider_out(dv), .is_slave_out(slv),
		.boot_type_invalid_out(inv), .cache_disable_out(cch),
		.module_state_field_out(dom), .cpu_release_out(rel),
		.boot_start_out(bst));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [51:0] exp_of(input logic [7:0] v);
		logic [3:0] t;
		logic b;
		logic [31:0] a;
		logic [4:0] m;
		t = v[7:4];
		b = !v[3] || t == 4'h0;
		a = (t == 4'h4 && !v[3]) ? 32'h0420_0000 : 32'h0010_0000;
		m = (t == 4'ha || t == 4'hf) ? 5'h14 : muls_tbl[5*v[2:0] +: 5];
		if (b) m = 5'h01;
		return {1'b1, v, a, m, b, b ? 2'h1 : 2'h2, t == 4'h2 || t == 4'ha,
			t inside {4'h1, 4'h3, 4'hb, 4'hc, 4'hd} || (t == 4'h9 && !v[3]),
			a == 32'h0010_0000};
	endfunction : exp_of
	task automatic chk(input logic [79:0] seen, input logic [79:0] wnt);
		n_checks++;
		if (seen !== wnt) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, wnt);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	initial begin
		repeat (4) @(posedge clk_in);
		for (int i = 0; i < 32; i++) begin
			rs = xs(rs);
			c = {i[4:0], rs[2:0]};
			if (c[7:4] == 4'h5) c[7:4] = 4'h7;
			if (!c[3] && (c[7:4] inside {4'h1, 4'h3, 4'h9, 4'hb, 4'hc, 4'hd}))
				c[3] = 1'b1;
			a3 = rs[3] ? 3'h2 : (rs[4] ? 3'h5 : 3'h0);
			nrst_in <= 1'b0;
			strap <= c;
			amem <= a3;
			expq.push_back({2'h3, 48'h0, (a3 == 3'h0 ? 2'h0 : 2'h3), 28'h0,
				exp_of(c)});
			@(posedge clk_in);
			nrst_in <= 1'b1;
			repeat (14) @(posedge clk_in);
			chk(80'(expq.size()), 80'h0);
			strap <= ~c;
			amem <= ~a3;
			repeat (3) @(posedge clk_in);
		end
		close_out();
	end
	always @(posedge clk_in) begin
		#1;
		if (bst === 1'b1) begin
			@(posedge clk_in);
			#1;
			want = expq.pop_front();
			chk({28'h0, rel, cap, addr, mul, byp, dv, slv, inv, cch},
				{28'h0, want[51:0]});
			chk(dom, want[131:52]);
		end
	end
	initial begin
		repeat (1500) @(posedge clk_in);
		n_mismatch++;
		close_out();
	end
endmodule : boot_mode_and_module_defaults_bench
`default_nettype wire
